// file: hw/tlm_link3w.sv
// Purpose: Three-wire master shifting one address byte and one data byte.
// Assumes: Address bit 7 high marks a read; slave samples on rising edge.
// Notes:   Data pin input is filtered through three flip-flops.
`timescale 1ns/1ps
module tlm_link3w #(
	parameter int HALF_CYC = tlm_pkg::LINK_HALF_CYC
)(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Transfer request.
	input  wire logic       start,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output logic            busy,
	output logic            done,
	output logic      [7:0] rdata,
	// Link pins.
	output logic            link_clk,
	output logic            link_cs,
	output logic            link_dio_out,
	output logic            link_dio_oe,
	input  wire logic       link_dio_in
);

	typedef struct packed {
		tlm_pkg::tlm_lnk_t st;
		logic [7:0]        cnt;
		logic [4:0]        bits;
		logic [15:0]       sh;
		logic              rd;
		logic [7:0]        rdata;
		logic              done;
		logic              sclk;
		logic              cs;
		logic              dout;
		logic              doe;
		logic              s1;
		logic              s2;
		logic              s3;
		logic              din;
	} tlm_lnk_st_t;

	tlm_lnk_st_t q;
	tlm_lnk_st_t n;

	always_comb
	begin
		n = q;
		n.done = 1'b0;
		n.s1 = link_dio_in;
		n.s2 = q.s1;
		n.s3 = q.s2;
		if (q.s2 == q.s3)
			n.din = q.s3;
		unique case (q.st)
			tlm_pkg::LK_IDLE:
			begin
				if (start)
				begin
					n.st   = tlm_pkg::LK_LOW;
					n.sh   = {addr, wdata};
					n.rd   = addr[tlm_pkg::LINK_RD_BIT];
					n.bits = '0;
					n.cnt  = '0;
					n.cs   = 1'b1;
					n.sclk = 1'b0;
					n.dout = addr[7];
					n.doe  = 1'b1;
				end
			end
			tlm_pkg::LK_LOW:
			begin
				n.cnt = q.cnt + 8'h01;
				if (q.cnt == 8'(HALF_CYC - 1))
				begin
					n.cnt  = '0;
					n.sclk = 1'b1;
					n.st   = tlm_pkg::LK_HIGH;
				end
			end
			tlm_pkg::LK_HIGH:
			begin
				n.cnt = q.cnt + 8'h01;
				if (q.cnt == 8'(HALF_CYC - 1))
				begin
					n.cnt  = '0;
					n.sclk = 1'b0;
					n.bits = q.bits + 5'h01;
					if (q.rd && q.bits >= 5'h08)
						n.rdata = {q.rdata[6:0], q.din};
					n.sh   = {q.sh[14:0], 1'b0};
					n.dout = q.sh[14];
					n.doe  = !(q.rd && q.bits >= 5'h07);
					if (q.bits == 5'(tlm_pkg::FRAME_BITS - 1))
						n.st = tlm_pkg::LK_FIN;
					else
						n.st = tlm_pkg::LK_LOW;
				end
			end
			tlm_pkg::LK_FIN:
			begin
				n.cs   = 1'b0;
				n.doe  = 1'b0;
				n.dout = 1'b0;
				n.done = 1'b1;
				n.st   = tlm_pkg::LK_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end

	assign busy         = (q.st != tlm_pkg::LK_IDLE);
	assign done         = q.done;
	assign rdata        = q.rdata;
	assign link_clk     = q.sclk;
	assign link_cs      = q.cs;
	assign link_dio_out = q.dout;
	assign link_dio_oe  = q.doe;

endmodule : tlm_link3w

// file: hw/tlm_lut_link_regs.sv
// Purpose: Temperature tables, live drive values and manual link registers.
// Assumes: Password and grant levels come from the host port logic.
// Notes:   Host reads answer two cycles after the request.
`timescale 1ns/1ps
module tlm_lut_link_regs #(
	parameter int         RANGE_W  = 2,
	parameter int         HALF_CYC = tlm_pkg::LINK_HALF_CYC,
	parameter logic [7:0] DRV_STAT_A = 8'h8C,
	parameter logic [7:0] DRV_STAT_B = 8'h8D,
	parameter logic [7:0] DRV_MOD    = 8'h0A,
	parameter logic [7:0] DRV_APC    = 8'h0B
)(
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Host register port.
	input  wire logic               host_wr,
	input  wire logic               host_rd,
	input  wire logic [7:0]         host_table,
	input  wire logic [7:0]         host_addr,
	input  wire logic [7:0]         host_wdata,
	output logic      [7:0]         host_rdata,
	output logic                    host_rvalid,
	// Access levels.
	input  wire logic               top_password,
	input  wire logic               lower_password,
	input  wire logic               table_rw_grant,
	input  wire logic               table_ro_grant,
	// Temperature.
	input  wire logic [7:0]         temperature_index,
	input  wire logic               temp_conv_done,
	// Mode bits.
	input  wire logic               modulation_manual_enable,
	input  wire logic               modulation_position_select,
	input  wire logic               apc_manual_enable,
	input  wire logic [RANGE_W-1:0] apc_range,
	// Drive values.
	output logic      [8:0]         mod_dac,
	output logic      [RANGE_W+7:0] apc_setpoint,
	// Link pins.
	output logic                    link_clk,
	output logic                    link_cs,
	output logic                    link_dio_out,
	output logic                    link_dio_oe,
	input  wire logic               link_dio_in
);

	// ------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                ctrl_start;
		logic                ctrl_dis;
		logic [7:0]          man_addr;
		logic [7:0]          man_wdata;
		logic [7:0]          man_rdata;
		logic [7:0]          stat_a;
		logic [7:0]          stat_b;
		logic [8:0]          mod_live;
		logic [7:0]          apc_dac;
		logic [RANGE_W+7:0]  apc_set;
		logic                rd_p1;
		tlm_pkg::tlm_rsrc_t  rd_src;
		logic [7:0]          rd_reg;
		logic [7:0]          host_rdata;
		logic                host_rvalid;
		tlm_pkg::tlm_load_t  ld;
		logic                conv_pend;
		logic                mod_pend;
		logic                apc_pend;
		logic                poll_pend;
		logic                polb_pend;
		logic [15:0]         poll_cnt;
		tlm_pkg::tlm_job_t   job;
		logic                clr_pend;
	} tlm_main_st_t;

	tlm_main_st_t q;
	tlm_main_st_t n;

	logic                      rd_ok;
	logic                      wr_ok;
	logic                      ln_start;
	logic [7:0]                ln_addr;
	logic [7:0]                ln_wdata;
	logic                      ln_busy;
	logic                      ln_done;
	logic [7:0]                ln_rdata;
	logic                      mod_we;
	logic                      apc_we;
	logic [tlm_pkg::MOD_AW-1:0] mod_ra;
	logic [tlm_pkg::APC_AW-1:0] apc_ra;
	logic [tlm_pkg::MOD_AW-1:0] mod_lk;
	logic [tlm_pkg::APC_AW-1:0] apc_lk;
	logic [7:0]                mod_q;
	logic [7:0]                apc_q;
	logic [7:0]                hidx;
	logic [6:0]                apc_half;

	// ------------------------------------------------------------------
	// Decoding helpers.
	// ------------------------------------------------------------------
	function automatic logic in_tbl(input logic [7:0] a,
	                                input logic [7:0] last);
		in_tbl = (a >= tlm_pkg::OFS_TBL_BASE) && (a <= last);
	endfunction : in_tbl

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		reg_read = tlm_pkg::RST_BYTE;
		unique case (a)
			tlm_pkg::OFS_LINK_CTRL:
				reg_read = {6'h00, q.ctrl_start, q.ctrl_dis};
			tlm_pkg::OFS_LINK_ADDR:  reg_read = q.man_addr;
			tlm_pkg::OFS_LINK_WDATA: reg_read = q.man_wdata;
			tlm_pkg::OFS_LINK_RDATA: reg_read = q.man_rdata;
			tlm_pkg::OFS_STAT_A:     reg_read = q.stat_a;
			tlm_pkg::OFS_STAT_B:     reg_read = q.stat_b;
			tlm_pkg::OFS_MOD_HI:     reg_read = q.mod_live[8:1];
			tlm_pkg::OFS_MOD_LO:     reg_read = {7'h00, q.mod_live[0]};
			tlm_pkg::OFS_APC_DAC:    reg_read = q.apc_dac;
			default:                 reg_read = tlm_pkg::RST_BYTE;
		endcase
	endfunction : reg_read

	// ------------------------------------------------------------------
	// Table index lookup.
	// ------------------------------------------------------------------
	always_comb
	begin
		hidx     = host_addr - tlm_pkg::OFS_TBL_BASE;
		apc_half = temperature_index[7:1];
		// Each entry spans 2 degrees for modulation.
		if (temperature_index > 8'(tlm_pkg::MOD_ENTRIES - 1))
			mod_lk = 7'(tlm_pkg::MOD_ENTRIES - 1);
		else
			mod_lk = temperature_index[6:0];
		// Each entry spans 4 degrees for the APC table.
		if (apc_half > 7'(tlm_pkg::APC_ENTRIES - 1))
			apc_lk = 6'(tlm_pkg::APC_ENTRIES - 1);
		else
			apc_lk = apc_half[5:0];
	end

	// ------------------------------------------------------------------
	// Next state.
	// ------------------------------------------------------------------
	always_comb
	begin
		n = q;
		rd_ok = top_password ||
		        (lower_password && (table_rw_grant || table_ro_grant));
		wr_ok = top_password || (lower_password && table_rw_grant);
		ln_start = 1'b0;
		ln_addr  = q.man_addr;
		ln_wdata = q.man_wdata;
		mod_we   = 1'b0;
		apc_we   = 1'b0;
		mod_ra   = mod_lk;
		apc_ra   = apc_lk;
		n.rd_p1       = 1'b0;
		n.host_rvalid = 1'b0;
		n.apc_set     = {apc_range, q.apc_dac};

		// Link arbitration: manual first, automatic only when enabled.
		// It runs before every setter so a set in the same cycle wins.
		if (q.job == tlm_pkg::JB_NONE && !ln_busy && !ln_done)
		begin
			if (q.ctrl_start && !q.clr_pend)
			begin
				ln_start = 1'b1;
				ln_addr  = q.man_addr;
				ln_wdata = q.man_wdata;
				n.job    = tlm_pkg::JB_MAN;
			end
			else if (!q.ctrl_dis)
			begin
				if (q.mod_pend)
				begin
					ln_start   = 1'b1;
					ln_addr    = DRV_MOD;
					ln_wdata   = q.mod_live[8:1];
					n.mod_pend = 1'b0;
					n.job      = tlm_pkg::JB_MOD;
				end
				else if (q.apc_pend)
				begin
					ln_start   = 1'b1;
					ln_addr    = DRV_APC;
					ln_wdata   = q.apc_dac;
					n.apc_pend = 1'b0;
					n.job      = tlm_pkg::JB_APC;
				end
				else if (q.polb_pend)
				begin
					ln_start    = 1'b1;
					ln_addr     = DRV_STAT_B;
					n.polb_pend = 1'b0;
					n.job       = tlm_pkg::JB_STB;
				end
				else if (q.poll_pend)
				begin
					ln_start    = 1'b1;
					ln_addr     = DRV_STAT_A;
					n.poll_pend = 1'b0;
					n.job       = tlm_pkg::JB_STA;
				end
			end
		end

		// Host reads.
		if (host_rd)
		begin
			n.rd_p1  = 1'b1;
			n.rd_src = tlm_pkg::RS_REG;
			n.rd_reg = tlm_pkg::RST_BYTE;
			mod_ra   = hidx[tlm_pkg::MOD_AW-1:0];
			apc_ra   = hidx[tlm_pkg::APC_AW-1:0];
			if (rd_ok)
			begin
				if (host_table == tlm_pkg::TBL_CTRL)
					n.rd_reg = reg_read(host_addr);
				else if (host_table == tlm_pkg::TBL_MOD &&
				         in_tbl(host_addr, tlm_pkg::OFS_MOD_LAST))
					n.rd_src = tlm_pkg::RS_MOD;
				else if (host_table == tlm_pkg::TBL_APC &&
				         in_tbl(host_addr, tlm_pkg::OFS_APC_LAST))
					n.rd_src = tlm_pkg::RS_APC;
			end
		end
		if (q.rd_p1)
		begin
			n.host_rvalid = 1'b1;
			unique case (q.rd_src)
				tlm_pkg::RS_MOD: n.host_rdata = mod_q;
				tlm_pkg::RS_APC: n.host_rdata = apc_q;
				default:         n.host_rdata = q.rd_reg;
			endcase
		end

		// Host writes.
		if (host_wr && wr_ok)
		begin
			if (host_table == tlm_pkg::TBL_MOD)
				mod_we = in_tbl(host_addr, tlm_pkg::OFS_MOD_LAST);
			if (host_table == tlm_pkg::TBL_APC)
				apc_we = in_tbl(host_addr, tlm_pkg::OFS_APC_LAST);
			if (host_table == tlm_pkg::TBL_CTRL)
			begin
				unique case (host_addr)
					tlm_pkg::OFS_LINK_CTRL:
					begin
						n.ctrl_dis = host_wdata[tlm_pkg::CTRL_DIS_BIT];
						if (host_wdata[tlm_pkg::CTRL_START_BIT])
							n.ctrl_start = 1'b1;
					end
					tlm_pkg::OFS_LINK_ADDR:  n.man_addr  = host_wdata;
					tlm_pkg::OFS_LINK_WDATA: n.man_wdata = host_wdata;
					tlm_pkg::OFS_MOD_HI:
					begin
						if (modulation_manual_enable)
						begin
							n.mod_live[8:1] = host_wdata;
							n.mod_pend      = 1'b1;
						end
					end
					tlm_pkg::OFS_MOD_LO:
					begin
						if (modulation_manual_enable)
						begin
							n.mod_live[0] = host_wdata[0];
							n.mod_pend    = 1'b1;
						end
					end
					tlm_pkg::OFS_APC_DAC:
					begin
						if (apc_manual_enable)
						begin
							n.apc_dac  = host_wdata;
							n.apc_pend = 1'b1;
						end
					end
					default:
					begin
					end
				endcase
			end
		end

		// Table loads after each temperature conversion.
		unique case (q.ld)
			tlm_pkg::LD_IDLE:
			begin
				if (q.conv_pend && !host_rd)
				begin
					n.conv_pend = 1'b0;
					n.ld        = tlm_pkg::LD_TAKE;
				end
			end
			tlm_pkg::LD_TAKE:
			begin
				n.ld = tlm_pkg::LD_IDLE;
				if (!modulation_manual_enable)
				begin
					if (modulation_position_select)
						n.mod_live = {mod_q, 1'b0};
					else
						n.mod_live = {1'b0, mod_q};
					n.mod_pend = 1'b1;
				end
				if (!apc_manual_enable)
				begin
					n.apc_dac  = apc_q;
					n.apc_pend = 1'b1;
				end
			end
		endcase
		if (temp_conv_done)
			n.conv_pend = 1'b1;

		// Status refresh timer.
		if (q.poll_cnt == 16'(tlm_pkg::REFRESH_CYC - 1))
		begin
			n.poll_cnt  = '0;
			n.poll_pend = 1'b1;
		end
		else
			n.poll_cnt = q.poll_cnt + 16'h0001;

		// Link completion.
		if (ln_done)
		begin
			n.job = tlm_pkg::JB_NONE;
			unique case (q.job)
				tlm_pkg::JB_MAN:
				begin
					if (q.man_addr[tlm_pkg::LINK_RD_BIT])
						n.man_rdata = ln_rdata;
					n.clr_pend = 1'b1;
				end
				tlm_pkg::JB_STA:
				begin
					n.stat_a    = ln_rdata;
					n.polb_pend = 1'b1;
				end
				tlm_pkg::JB_STB: n.stat_b = ln_rdata;
				default:
				begin
				end
			endcase
		end

		// Start bit drops one cycle after the read data landed.
		if (q.clr_pend)
		begin
			n.clr_pend = 1'b0;
			if (!(host_wr && wr_ok && host_table == tlm_pkg::TBL_CTRL &&
			      host_addr == tlm_pkg::OFS_LINK_CTRL &&
			      host_wdata[tlm_pkg::CTRL_START_BIT]))
				n.ctrl_start = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end

	// ------------------------------------------------------------------
	// Tables and link master.
	// ------------------------------------------------------------------
	tlm_tbl_mem #(
		.W     (8),
		.DEPTH (tlm_pkg::MOD_ENTRIES),
		.AW    (tlm_pkg::MOD_AW)
	) u_mod_tbl (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (mod_we),
		.wr_addr (hidx[tlm_pkg::MOD_AW-1:0]),
		.wr_data (host_wdata),
		.rd_addr (mod_ra),
		.rd_data (mod_q)
	);

	tlm_tbl_mem #(
		.W     (8),
		.DEPTH (tlm_pkg::APC_ENTRIES),
		.AW    (tlm_pkg::APC_AW)
	) u_apc_tbl (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (apc_we),
		.wr_addr (hidx[tlm_pkg::APC_AW-1:0]),
		.wr_data (host_wdata),
		.rd_addr (apc_ra),
		.rd_data (apc_q)
	);

	tlm_link3w #(
		.HALF_CYC (HALF_CYC)
	) u_link (
		.clk          (clk),
		.rst_n        (rst_n),
		.start        (ln_start),
		.addr         (ln_addr),
		.wdata        (ln_wdata),
		.busy         (ln_busy),
		.done         (ln_done),
		.rdata        (ln_rdata),
		.link_clk     (link_clk),
		.link_cs      (link_cs),
		.link_dio_out (link_dio_out),
		.link_dio_oe  (link_dio_oe),
		.link_dio_in  (link_dio_in)
	);

	assign host_rdata   = q.host_rdata;
	assign host_rvalid  = q.host_rvalid;
	assign mod_dac      = q.mod_live;
	assign apc_setpoint = q.apc_set;

endmodule : tlm_lut_link_regs

// file: hw/tlm_pkg.sv
// Purpose: Shared constants and types for the table and link register block.
// Assumes: 250 MHz core clock.
// Notes:   Offsets are byte addresses inside each table page.
package tlm_pkg;

	// ------------------------------------------------------------------
	// Table pages and register offsets.
	// ------------------------------------------------------------------
	localparam logic [7:0] TBL_CTRL       = 8'h02;
	localparam logic [7:0] TBL_MOD        = 8'h04;
	localparam logic [7:0] TBL_APC        = 8'h06;
	localparam logic [7:0] OFS_TBL_BASE   = 8'h80;
	localparam logic [7:0] OFS_MOD_LAST   = 8'hC7;
	localparam logic [7:0] OFS_APC_LAST   = 8'hA3;
	localparam logic [7:0] OFS_MOD_HI     = 8'h82;
	localparam logic [7:0] OFS_MOD_LO     = 8'h83;
	localparam logic [7:0] OFS_APC_DAC    = 8'hCD;
	localparam logic [7:0] OFS_LINK_CTRL  = 8'hF8;
	localparam logic [7:0] OFS_LINK_ADDR  = 8'hF9;
	localparam logic [7:0] OFS_LINK_WDATA = 8'hFA;
	localparam logic [7:0] OFS_LINK_RDATA = 8'hFB;
	localparam logic [7:0] OFS_STAT_A     = 8'hFC;
	localparam logic [7:0] OFS_STAT_B     = 8'hFD;
	localparam logic [7:0] RST_BYTE       = 8'h00;

	// ------------------------------------------------------------------
	// Field positions and table sizes.
	// ------------------------------------------------------------------
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_DIS_BIT   = 0;
	localparam int LINK_RD_BIT    = 7;
	localparam int MOD_ENTRIES    = 72;
	localparam int APC_ENTRIES    = 36;
	localparam int MOD_AW         = 7;
	localparam int APC_AW         = 6;
	localparam int FRAME_BITS     = 16;

	// ------------------------------------------------------------------
	// Timing.
	// ------------------------------------------------------------------
	localparam int CLK_NS        = 4;
	localparam int LINK_HALF_NS  = 100;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int REFRESH_NS    = 10000;
	localparam int REFRESH_CYC   = REFRESH_NS / CLK_NS;

	// ------------------------------------------------------------------
	// State types.
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {LK_IDLE, LK_LOW, LK_HIGH, LK_FIN} tlm_lnk_t;
	typedef enum logic [1:0] {RS_REG, RS_MOD, RS_APC} tlm_rsrc_t;
	typedef enum logic {LD_IDLE, LD_TAKE} tlm_load_t;
	typedef enum logic [2:0] {
		JB_NONE, JB_MAN, JB_MOD, JB_APC, JB_STA, JB_STB
	} tlm_job_t;

endpackage : tlm_pkg

// file: hw/tlm_tbl_mem.sv
// Purpose: Byte table with one write port and a registered read port.
// Assumes: Write address is always below DEPTH.
// Notes:   All cells clear to zero under reset.
`timescale 1ns/1ps
module tlm_tbl_mem #(
	parameter int W     = 8,
	parameter int DEPTH = 72,
	parameter int AW    = 7
)(
	// Clock and reset.
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Write port.
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	// Read port.
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] cells;
		logic [W-1:0]            rdata;
	} tlm_mem_st_t;

	tlm_mem_st_t q;
	tlm_mem_st_t n;

	always_comb
	begin
		n = q;
		if (wr_en)
			n.cells[wr_addr] = wr_data;
		n.rdata = q.cells[rd_addr];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end

	assign rd_data = q.rdata;

endmodule : tlm_tbl_mem

// file: sim/test_tlm_lut_link_regs.sv
// Purpose: Register-level test of the table and link block.
// Assumes: Short link half period; driver model on the link.
// Notes:   Host requests launch on rising clock edges.
`timescale 1ns/1ps
module test_tlm_lut_link_regs;
	logic       clk, rst_n, host_wr, host_rd, temp_conv_done, host_rvalid;
	logic       top_password, lower_password, table_rw_grant, table_ro_grant;
	logic       modulation_manual_enable, modulation_position_select;
	logic       apc_manual_enable, link_clk, link_cs;
	logic       link_dio_out, link_dio_oe, dio_in, drv_dio, rv;
	logic [1:0] apc_range;
	logic [7:0] host_table, host_addr, host_wdata, host_rdata, v, mv, av;
	logic [7:0] temperature_index;
	logic [8:0] mod_dac;
	logic [9:0] apc_setpoint;
	int         fails, checked;
	int         ti[3] = '{0, 1, 71};

	tlm_lut_link_regs #(.HALF_CYC(8)) i_tlm_lut_link_regs (.clk, .rst_n,
		.host_wr, .host_rd, .host_table, .host_addr, .host_wdata, .host_rdata,
		.host_rvalid, .top_password, .lower_password, .table_rw_grant,
		.table_ro_grant, .temperature_index, .temp_conv_done,
		.modulation_manual_enable, .modulation_position_select,
		.apc_manual_enable, .apc_range, .mod_dac, .apc_setpoint, .link_clk,
		.link_cs, .link_dio_out, .link_dio_oe, .link_dio_in(dio_in));
	tlm_drv_model i_tlm_drv_model (.link_clk, .link_cs, .link_dio(dio_in),
		.drv_dio);

	assign dio_in = link_dio_oe ? link_dio_out : drv_dio;
	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input string s, input logic [9:0] e, g);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] t, a, d);
		host_wr <= 1'b1;
		host_table <= t;
		host_addr <= a;
		host_wdata <= d;
		@(posedge clk);
		host_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rq(input logic [7:0] t, a);
		host_rd <= 1'b1;
		host_table <= t;
		host_addr <= a;
		@(posedge clk);
		host_rd <= 1'b0;
		@(posedge clk);
		#1;
		v = host_rdata;
		rv = host_rvalid;
		@(posedge clk);
	endtask : rq
	task automatic rd(input logic [7:0] t, a, e, input string s);
		rq(t, a);
		chk(s, {2'b01, e}, {1'b0, rv, v});
	endtask : rd
	task automatic lv(input logic [3:0] x);
		{top_password, lower_password, table_rw_grant, table_ro_grant} <= x;
		@(posedge clk);
	endtask : lv
	task automatic conv(input logic [7:0] t);
		temperature_index <= t;
		@(posedge clk);
		temp_conv_done <= 1'b1;
		@(posedge clk);
		temp_conv_done <= 1'b0;
		repeat (20) @(posedge clk);
	endtask : conv
	task automatic xfer(input logic [7:0] a);
		v = 8'hFF;
		wr(8'h02, 8'hF9, a);
		wr(8'h02, 8'hF8, 8'h03);
		for (int i = 0; i < 200 && v !== 8'h01; i++)
			rq(8'h02, 8'hF8);
		chk("start", 10'h001, {2'b0, v});
	endtask : xfer
	task automatic results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		results();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		{clk, rst_n, host_wr, host_rd, temp_conv_done} = '0;
		{top_password, lower_password, table_rw_grant, table_ro_grant} = '0;
		{modulation_manual_enable, modulation_position_select} = '0;
		{apc_manual_enable, apc_range, temperature_index} = '0;
		{host_table, host_addr, host_wdata} = '0;
		v = 8'hFF;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		lv(4'b1000);
		wr(8'h02, 8'hF8, 8'h01);
		rd(8'h02, 8'hF9, 8'h00, "addr reset");
		wr(8'h02, 8'hF9, 8'hAA);
		lv(4'b0100);
		rd(8'h02, 8'hF9, 8'h00, "lower only");
		lv(4'b0101);
		wr(8'h02, 8'hF9, 8'h55);
		rd(8'h02, 8'hF9, 8'hAA, "ro grant");
		lv(4'b0110);
		wr(8'h02, 8'hF9, 8'h55);
		wr(8'h02, 8'hFB, 8'hFF);
		rd(8'h02, 8'hF9, 8'h55, "rw grant");
		rd(8'h02, 8'hFB, 8'h00, "read data ro");
		$display("test access done");
		wr(8'h02, 8'hFA, 8'hC3);
		xfer(8'h12);
		chk("drv", 10'h0C3, {2'b0, i_tlm_drv_model.mem[18]});
		xfer(8'h92);
		rd(8'h02, 8'hFB, 8'hC3, "manual read");
		repeat (3000) @(posedge clk);
		rd(8'h02, 8'hFC, 8'h00, "no poll");
		wr(8'h02, 8'hF8, 8'h00);
		repeat (3000) @(posedge clk);
		rd(8'h02, 8'hFC, 8'h56, "status a");
		rd(8'h02, 8'hFD, 8'h57, "status b");
		$display("test link done");
		foreach (ti[k])
		begin
			mv = 8'h41 + 8'(ti[k]);
			av = 8'h21 + 8'(ti[k]);
			wr(8'h04, 8'h80 + 8'(ti[k]), mv);
			wr(8'h06, 8'h80 + 8'(ti[k] / 2), av);
			apc_range <= 2'(k);
			modulation_position_select <= k[0];
			conv(8'(ti[k]));
			chk("mod", k[0] ? {1'b0, mv, 1'b0} : {2'b0, mv}, {1'b0, mod_dac});
			chk("apc", {2'(k), av}, apc_setpoint);
		end
		for (int j = 0; j < tlm_pkg::MOD_ENTRIES; j++)
			wr(8'h04, 8'h80 + 8'(j), 8'h3C);
		for (int j = 0; j < tlm_pkg::APC_ENTRIES; j++)
			wr(8'h06, 8'h80 + 8'(j), 8'h5A);
		rd(8'h04, 8'hC7, 8'h3C, "mod table");
		rd(8'h06, 8'hA3, 8'h5A, "apc table");
		conv(8'h21);
		chk("mod flat", 10'h03C, {1'b0, mod_dac});
		chk("apc flat", {2'h2, 8'h5A}, apc_setpoint);
		$display("test tables done");
		modulation_manual_enable <= 1'b1;
		apc_manual_enable <= 1'b1;
		@(posedge clk);
		wr(8'h02, 8'h82, 8'h9A);
		wr(8'h02, 8'h83, 8'h01);
		wr(8'h02, 8'hCD, 8'h77);
		conv(8'h00);
		chk("mod manual", 10'h135, {1'b0, mod_dac});
		chk("apc manual", {apc_range, 8'h77}, apc_setpoint);
		$display("test manual done");
		results();
	end
endmodule : test_tlm_lut_link_regs

// file: sim/tlm_drv_model.sv
// Purpose: Behavioural laser driver on the three-wire link.
// Assumes: Address first, MSB first; address bit 7 marks a read.
// Notes:   Read bits change on falling link clock edges.
`timescale 1ns/1ps
module tlm_drv_model (
	// Link pins.
	input wire logic link_clk,
	input wire logic link_cs,
	input wire logic link_dio,
	output logic     drv_dio
);
	logic [7:0]  mem [128];
	logic [7:0]  adr;
	logic [15:0] sh;
	int          n;

	initial
	begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		drv_dio = 1'b0;
		n = 0;
	end
	always @(posedge link_cs)
		n = 0;
	// Released line shows the inverse of its last value.
	always @(negedge link_cs)
		drv_dio = ~drv_dio;
	always @(posedge link_clk)
	begin
		sh = {sh[14:0], link_dio};
		n = n + 1;
		if (n == 8)
			adr = sh[7:0];
		if (n == 16 && !adr[7])
			mem[adr[6:0]] = sh[7:0];
	end
	always @(negedge link_clk)
		if (link_cs && n >= 8 && n < 16 && adr[7])
			drv_dio = mem[adr[6:0]][15 - n];
endmodule : tlm_drv_model

// file: sim/tlm_lut_link_regs_properties.sv
// Purpose: Port assertions for the table and link block.
// Assumes: Bound to every instance of the top module.
// Notes:   Table loads land within twelve cycles of a conversion.
`timescale 1ns/1ps
module tlm_lut_link_regs_properties #(
	parameter int RANGE_W = 2
)(
	// Clock, reset and host port.
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               host_wr,
	input wire logic               host_rd,
	input wire logic [7:0]         host_rdata,
	input wire logic               host_rvalid,
	// Levels and modes.
	input wire logic               top_password,
	input wire logic               lower_password,
	input wire logic               table_rw_grant,
	input wire logic               table_ro_grant,
	input wire logic               temp_conv_done,
	input wire logic               modulation_manual_enable,
	input wire logic               apc_manual_enable,
	input wire logic [RANGE_W-1:0] apc_range,
	// Drive values.
	input wire logic [8:0]         mod_dac,
	input wire logic [RANGE_W+7:0] apc_setpoint
);
	logic [3:0] since_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Counts cycles since the last conversion pulse.
	always_ff @(posedge clk)
		if (temp_conv_done)
			since_r <= 4'h0;
		else if (!rst_n)
			since_r <= 4'hF;
		else if (since_r != 4'hF)
			since_r <= since_r + 4'h1;

	rvalid_delay_a:
	assert property (host_rd |-> ##2 host_rvalid)
		else $error("read not answered");
	rvalid_cause_a:
	assert property (host_rvalid |-> $past(host_rd, 2))
		else $error("answer without read");
	read_denied_a:
	assert property (host_rd && !top_password && !(lower_password &&
		(table_rw_grant || table_ro_grant)) |-> ##2 host_rdata == 8'h00)
		else $error("denied read gave data");
	mod_hold_a:
	assert property (modulation_manual_enable && !$past(host_wr) &&
		$past(modulation_manual_enable, 4) |-> $stable(mod_dac))
		else $error("modulation moved in manual mode");
	apc_hold_a:
	assert property (apc_manual_enable && !$past(host_wr, 2) &&
		$past(apc_manual_enable, 4) |-> $stable(apc_setpoint[7:0]))
		else $error("apc moved in manual mode");
	apc_range_a:
	assert property ($past(rst_n) |->
		apc_setpoint[RANGE_W+7:8] == $past(apc_range))
		else $error("range bits wrong");
	mod_load_a:
	assert property ($changed(mod_dac) && !modulation_manual_enable
		|-> since_r < 4'hC)
		else $error("modulation moved without conversion");
	apc_load_a:
	assert property ($changed(apc_setpoint[7:0]) && !apc_manual_enable
		|-> since_r < 4'hC)
		else $error("apc moved without conversion");
endmodule : tlm_lut_link_regs_properties

bind tlm_lut_link_regs tlm_lut_link_regs_properties #(.RANGE_W(RANGE_W))
	i_props (.clk, .rst_n, .host_wr, .host_rd, .host_rdata, .host_rvalid,
	.top_password, .lower_password, .table_rw_grant, .table_ro_grant,
	.temp_conv_done, .modulation_manual_enable, .apc_manual_enable,
	.apc_range, .mod_dac, .apc_setpoint);
